// ### pgc_regs.sv
// Top of the packet statistics bank: AHB-Lite slave, configuration words and CRC flags.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pgc_regs
  import pgc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [DATA_W-1:0] hwdata,
  output logic [DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pgc_pkt_s txPkt,
  input wire pgc_pkt_s rxPkt,
  input wire logic rxDaValid,
  input wire logic [PAT_W-1:0] rxDestAddr,
  output logic [PAT_W-1:0] userPattern,
  output logic daHit,
  output logic daMiss
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Address phase decode
  // ****************************************
  logic active;
  logic accept;
  logic addrOk;
  logic rdAccept;
  logic wrAccept;
  logic [IDX_W-1:0] addrIdx;
  logic [SEQ_BYTE_W-1:0] addrByte;

  assign active = (htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ);
  assign accept = hsel && hready && active;
  assign addrOk = inPage(haddr);
  assign addrIdx = regIdx(haddr);
  assign addrByte = addrIdx[SEQ_BYTE_W-1:0];
  assign rdAccept = accept && !hwrite;
  assign wrAccept = accept && hwrite && addrOk && (hsize == HSIZE_WORD);

  // ****************************************
  // Write data phase
  // ****************************************
  logic wrPend_q;
  logic [IDX_W-1:0] wrIdx_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= '0;
    end else begin
      wrPend_q <= wrAccept;
      if (wrAccept) begin
        wrIdx_q <= addrIdx;
      end
    end
  end

  // ****************************************
  // Pattern and match words
  // ****************************************
  logic [REG_W-1:0] rwReg_q [NUM_RW];
  logic [PAT_W-1:0] matchValue;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RW; gi++) begin : g_rw
      logic hit;
      assign hit = wrPend_q && (wrIdx_q == RW_IDX[gi]);
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          rwReg_q[gi] <= REG_RESET;
        end else if (hit) begin
          rwReg_q[gi] <= hwdata[REG_W-1:0];
        end
      end
    end
  endgenerate

  assign userPattern = {rwReg_q[RW_PAT_HIGH], rwReg_q[RW_PAT_MID], rwReg_q[RW_PAT_LOW]};
  assign matchValue = {rwReg_q[RW_DA_HIGH], rwReg_q[RW_DA_MID], rwReg_q[RW_DA_LOW]};

  pgc_da_match u_match (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .daValid(rxDaValid),
    .destAddr(rxDestAddr),
    .matchValue(matchValue),
    .daHit(daHit),
    .daMiss(daMiss)
  );

  // ****************************************
  // CRC status of the last packet per direction
  // ****************************************
  logic [FLAG_W-1:0] crcFlag_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      crcFlag_q <= '0;
    end else begin
      if (txPkt.done) begin
        crcFlag_q[FLAG_TX] <= txPkt.crcErr;
      end
      if (rxPkt.done) begin
        crcFlag_q[FLAG_RX] <= rxPkt.crcErr;
      end
    end
  end

  // ****************************************
  // Statistics groups and their ordered-read tracking
  // ****************************************
  pgc_pkt_s grpPkt [NUM_GRP];
  pgc_stat_s grpLive [NUM_GRP];
  pgc_stat_s grpHeld [NUM_GRP];

  assign grpPkt[GRP_TX] = txPkt;
  assign grpPkt[GRP_RX] = rxPkt;

  // Any other bus access between the three reads breaks the sequence, so a
  // second agent touching the bank cannot make a partial read clear the totals.
  generate
    for (gi = 0; gi < NUM_GRP; gi++) begin : g_grp
      pgc_seq_e seq_q;
      pgc_seq_e seq_d;
      logic isFirst;
      logic isSecond;
      logic isThird;
      logic snapNow;
      logic clrNow;

      assign isFirst = rdAccept && (addrByte == SEQ_FIRST[gi]);
      assign isSecond = rdAccept && (addrByte == SEQ_FIRST[gi] + SEQ_STEP);
      assign isThird = rdAccept && (addrByte == SEQ_FIRST[gi] + SEQ_STEP + SEQ_STEP);

      always_comb begin
        seq_d = seq_q;
        snapNow = 1'b0;
        clrNow = 1'b0;
        if (accept) begin
          seq_d = SEQ_IDLE;
          if (isFirst) begin
            seq_d = SEQ_ONE;
            snapNow = 1'b1;
          end else begin
            case (seq_q)
              SEQ_ONE: begin
                if (isSecond) begin
                  seq_d = SEQ_TWO;
                end
              end
              SEQ_TWO: begin
                if (isThird) begin
                  clrNow = 1'b1;
                end
              end
              default: begin
                seq_d = SEQ_IDLE;
              end
            endcase
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          seq_q <= SEQ_IDLE;
        end else begin
          seq_q <= seq_d;
        end
      end

      pgc_stat_group u_stat (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pkt(grpPkt[gi]),
        .snap(snapNow),
        .clear(clrNow),
        .live(grpLive[gi]),
        .held(grpHeld[gi])
      );

      chk_seq_clear: assert property (isFirst ##1 !accept ##1 isSecond ##1 !accept
        ##1 isThird |=> grpLive[gi].total <= CNT_ONE && grpLive[gi].faults <= FAULT_ONE)
        else $error("ordered reads did not clear the group");
      chk_seq_broken: assert property (isFirst ##1 !accept ##1 (accept && !isSecond)
        ##1 !accept ##1 isSecond ##1 !accept ##1 isThird |-> !clrNow)
        else $error("interrupted read order cleared the group");
      cov_seq_clear: cover property (clrNow);
    end
  endgenerate

  // ****************************************
  // Read data selection
  // ****************************************
  // A read right behind a write to the same word returns the new data.
  logic fwd;
  logic [DATA_W-1:0] rdValue;

  assign fwd = wrPend_q && (wrIdx_q == addrIdx);

  always_comb begin
    rdValue = WORD_ZERO;
    if (!addrOk) begin
      rdValue = WORD_ZERO;
    end else if (addrIdx == IDX_CRC) begin
      rdValue[FLAG_W-1:0] = crcFlag_q;
    end else if (addrIdx == IDX_TX_LOW) begin
      rdValue[REG_W-1:0] = grpLive[GRP_TX].total[REG_W-1:0];
    end else if (addrIdx == IDX_TX_HIGH) begin
      rdValue[REG_W-1:0] = grpHeld[GRP_TX].total[CNT_W-1:REG_W];
    end else if (addrIdx == IDX_TX_FAULT) begin
      rdValue[REG_W-1:0] = grpHeld[GRP_TX].faults;
    end else if (addrIdx == IDX_RX_LOW) begin
      rdValue[REG_W-1:0] = grpLive[GRP_RX].total[REG_W-1:0];
    end else if (addrIdx == IDX_RX_HIGH) begin
      rdValue[REG_W-1:0] = grpHeld[GRP_RX].total[CNT_W-1:REG_W];
    end else if (addrIdx == IDX_RX_FAULT) begin
      rdValue[REG_W-1:0] = grpHeld[GRP_RX].faults;
    end else begin
      for (int i = 0; i < NUM_RW; i++) begin
        if (addrIdx == RW_IDX[i]) begin
          rdValue[REG_W-1:0] = fwd ? hwdata[REG_W-1:0] : rwReg_q[i];
        end
      end
    end
  end

  // ****************************************
  // Bus answer, zero wait states and always OKAY
  // ****************************************
  logic [DATA_W-1:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hrdata_q <= WORD_ZERO;
      hreadyout_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
      if (rdAccept) begin
        hrdata_q <= rdValue;
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // ****************************************
  // Checks
  // ****************************************
  chk_pattern_mid: assert property (wrPend_q && (wrIdx_q == IDX_PAT_MID) |=>
    userPattern[CNT_W-1:REG_W] == $past(hwdata[REG_W-1:0]))
    else $error("pattern middle word not written");
  chk_pattern_high: assert property (wrPend_q && (wrIdx_q == IDX_PAT_HIGH) |=>
    userPattern[PAT_W-1:CNT_W] == $past(hwdata[REG_W-1:0]))
    else $error("pattern high word not written");
  chk_pattern_low: assert property (wrPend_q && (wrIdx_q == IDX_PAT_LOW) |=>
    userPattern[REG_W-1:0] == $past(hwdata[REG_W-1:0]))
    else $error("pattern low word not written");
  chk_match_low: assert property (wrPend_q && (wrIdx_q == IDX_DA_LOW) |=>
    matchValue[REG_W-1:0] == $past(hwdata[REG_W-1:0]))
    else $error("match low word not written");
  chk_match_mid: assert property (wrPend_q && (wrIdx_q == IDX_DA_MID) |=>
    matchValue[CNT_W-1:REG_W] == $past(hwdata[REG_W-1:0]))
    else $error("match middle word not written");
  chk_match_high: assert property (wrPend_q && (wrIdx_q == IDX_DA_HIGH) |=>
    matchValue[PAT_W-1:CNT_W] == $past(hwdata[REG_W-1:0]))
    else $error("match high word not written");
  chk_rx_crc_flag: assert property (rxPkt.done ##1
    (!rxPkt.done && rdAccept && addrOk && addrIdx == IDX_CRC) |=>
    hrdata[FLAG_RX] == $past(rxPkt.crcErr, 2))
    else $error("receive CRC status wrong");
  chk_tx_crc_flag: assert property (txPkt.done ##1
    (!txPkt.done && rdAccept && addrOk && addrIdx == IDX_CRC) |=>
    hrdata[FLAG_TX] == $past(txPkt.crcErr, 2) && hrdata[DATA_W-1:FLAG_W] == '0)
    else $error("transmit CRC status wrong");
  chk_tx_upper: assert property ((rdAccept && addrOk && addrIdx == IDX_TX_LOW)
    ##1 !accept ##1 (rdAccept && addrOk && addrIdx == IDX_TX_HIGH) |=>
    hrdata[REG_W-1:0] == $past(grpLive[GRP_TX].total[CNT_W-1:REG_W], 3))
    else $error("sent upper half not coherent");
  chk_rx_upper: assert property ((rdAccept && addrOk && addrIdx == IDX_RX_LOW)
    ##1 !accept ##1 (rdAccept && addrOk && addrIdx == IDX_RX_HIGH) |=>
    hrdata[REG_W-1:0] == $past(grpLive[GRP_RX].total[CNT_W-1:REG_W], 3))
    else $error("received upper half not coherent");
  cov_read_after_write: cover property (fwd && rdAccept);

endmodule

// ### pgc_pkg.sv
// Register map, field layout, state codes and carriers of the packet statistics bank.
// Overview of operation
// - Pattern bits 31..16 writable, reset zero.
// - Pattern bits 47..32 at next offset.
// - Pattern bits 15..0 writable, reset zero.
// - Match value bits 15..0 read-write, reset zero.
// - Match value bits 31..16 at next offset.
// - Match value bits 47..32 at third offset.
// - Compare packet destination address with match value.
// - Status bit 1 flags receive CRC error.
// - Status bit 0 transmit CRC error, upper bits zero.
// - Count sent packets, low half readable.
// - Sent count upper half at next offset.
// - Count sent packets carrying a CRC error.
// - Ascending read of sent group clears it.
// - Count received packets, low half readable.
// - Ascending read of receive group clears it.
// - Received count upper half at next offset.
// - Count received packets carrying a CRC error.
package pgc_pkg;

  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned PAT_W = 48;
  localparam int unsigned IDX_W = 12;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned SEQ_BYTE_W = 8;
  localparam int unsigned FLAG_W = 2;
  localparam int unsigned FLAG_TX = 0;
  localparam int unsigned FLAG_RX = 1;
  localparam int unsigned NUM_RW = 6;
  localparam int unsigned NUM_GRP = 2;
  localparam int unsigned GRP_TX = 0;
  localparam int unsigned GRP_RX = 1;
  localparam int unsigned RW_PAT_LOW = 0;
  localparam int unsigned RW_PAT_MID = 1;
  localparam int unsigned RW_PAT_HIGH = 2;
  localparam int unsigned RW_DA_LOW = 3;
  localparam int unsigned RW_DA_MID = 4;
  localparam int unsigned RW_DA_HIGH = 5;

  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_PAT_LOW = 12'h625;
  localparam logic [IDX_W-1:0] IDX_PAT_MID = 12'h626;
  localparam logic [IDX_W-1:0] IDX_PAT_HIGH = 12'h627;
  localparam logic [IDX_W-1:0] IDX_DA_LOW = 12'h628;
  localparam logic [IDX_W-1:0] IDX_DA_MID = 12'h629;
  localparam logic [IDX_W-1:0] IDX_DA_HIGH = 12'h62a;
  localparam logic [IDX_W-1:0] IDX_CRC = 12'h638;
  localparam logic [IDX_W-1:0] IDX_TX_LOW = 12'h639;
  localparam logic [IDX_W-1:0] IDX_TX_HIGH = 12'h63a;
  localparam logic [IDX_W-1:0] IDX_TX_FAULT = 12'h63b;
  localparam logic [IDX_W-1:0] IDX_RX_LOW = 12'h63c;
  localparam logic [IDX_W-1:0] IDX_RX_HIGH = 12'h63d;
  localparam logic [IDX_W-1:0] IDX_RX_FAULT = 12'h63e;
  localparam logic [IDX_W-1:0] RW_IDX [NUM_RW] = '{IDX_PAT_LOW, IDX_PAT_MID, IDX_PAT_HIGH,
    IDX_DA_LOW, IDX_DA_MID, IDX_DA_HIGH};
  localparam logic [SEQ_BYTE_W-1:0] SEQ_FIRST [NUM_GRP] = '{8'h39, 8'h3c};
  localparam logic [SEQ_BYTE_W-1:0] SEQ_STEP = 8'h01;

  // ****************************************
  // Reset values and bus codes
  // ****************************************
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [REG_W-1:0] FAULT_ONE = 16'h0001;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_ONE = 3'h2,
    SEQ_TWO = 3'h4
  } pgc_seq_e;

  typedef struct packed {
    logic done;
    logic crcErr;
  } pgc_pkt_s;

  typedef struct packed {
    logic [CNT_W-1:0] total;
    logic [REG_W-1:0] faults;
  } pgc_stat_s;

  localparam pgc_stat_s STAT_RESET = '{total: 32'h0000_0000, faults: 16'h0000};

  function automatic logic inPage(input logic [DATA_W-1:0] addr);
    return (addr[ADDR_LSB-1:0] == '0) && (addr[DATA_W-1:IDX_W+ADDR_LSB] == '0);
  endfunction

  function automatic logic [IDX_W-1:0] regIdx(input logic [DATA_W-1:0] addr);
    return addr[IDX_W+ADDR_LSB-1:ADDR_LSB];
  endfunction

endpackage

// ### pgc_stat_group.sv
// Packet and CRC-error counters of one direction with a snapshot for ordered reads.
`timescale 1ns/1ps
module pgc_stat_group
  import pgc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire pgc_pkt_s pkt,
  input wire logic snap,
  input wire logic clear,
  output pgc_stat_s live,
  output pgc_stat_s held
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  pgc_stat_s live_q;
  pgc_stat_s live_d;
  pgc_stat_s held_q;

  // A packet finishing in the clearing cycle is counted after the clear, so it is not lost.
  // Counters wrap on overflow.
  always_comb begin
    live_d = clear ? STAT_RESET : live_q;
    if (pkt.done) begin
      live_d.total = live_d.total + CNT_ONE;
      if (pkt.crcErr) begin
        live_d.faults = live_d.faults + FAULT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      live_q <= STAT_RESET;
      held_q <= STAT_RESET;
    end else begin
      live_q <= live_d;
      if (snap) begin
        held_q <= live_q;
      end else if (clear) begin
        held_q <= STAT_RESET;
      end
    end
  end

  assign live = live_q;
  assign held = held_q;

  chk_total_count: assert property (pkt.done && !clear |=>
    live_q.total == $past(live_q.total) + CNT_ONE)
    else $error("packet total did not advance by one");
  chk_fault_count: assert property (pkt.done && pkt.crcErr && !clear |=>
    live_q.faults == $past(live_q.faults) + FAULT_ONE)
    else $error("error total did not advance by one");
  chk_count_hold: assert property (!pkt.done && !clear |=> $stable(live_q))
    else $error("totals changed without a packet");
  chk_clear_zero: assert property (clear && !pkt.done |=> live_q == STAT_RESET)
    else $error("totals not cleared");
  cov_clear_with_pkt: cover property (clear && pkt.done);

endmodule

// ### pgc_da_match.sv
// Destination address comparator against the programmed match value.
`timescale 1ns/1ps
module pgc_da_match
  import pgc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic daValid,
  input wire logic [PAT_W-1:0] destAddr,
  input wire logic [PAT_W-1:0] matchValue,
  output logic daHit,
  output logic daMiss
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic daHit_q;
  logic daMiss_q;
  logic same;

  assign same = (destAddr == matchValue);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      daHit_q <= 1'b0;
      daMiss_q <= 1'b0;
    end else begin
      daHit_q <= daValid && same;
      daMiss_q <= daValid && !same;
    end
  end

  assign daHit = daHit_q;
  assign daMiss = daMiss_q;

  chk_da_hit: assert property (daValid && same |=> daHit_q && !daMiss_q)
    else $error("matching address not reported as hit");
  chk_da_quiet: assert property (!daValid |=> !daHit_q && !daMiss_q)
    else $error("match result without a checked address");
  cov_da_hit: cover property (daHit_q);

endmodule

// ### pgc_regs_tb.sv
// Self-checking testbench of the packet statistics register bank.
`timescale 1ns/1ps
module tb
  import pgc_pkg::*;
;
  // ****************************************
  // Stimulus signals and counters
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [DATA_W-1:0] haddr = WORD_ZERO;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [DATA_W-1:0] hwdata = WORD_ZERO;
  wire logic [DATA_W-1:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic hready;
  pgc_pkt_s txPkt = '0;
  pgc_pkt_s rxPkt = '0;
  logic rxDaValid = 1'b0;
  logic [PAT_W-1:0] rxDestAddr = 48'h0000_0000_0000;
  wire logic [PAT_W-1:0] userPattern;
  wire logic daHit;
  wire logic daMiss;
  int fails = 0;
  int totalChecks = 0;
  logic [REG_W-1:0] pat [NUM_RW];

  // The single slave drives the bus ready itself.
  assign hready = hreadyout;

  pgc_regs u_pgc_regs (
    .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txPkt(txPkt), .rxPkt(rxPkt),
    .rxDaValid(rxDaValid), .rxDestAddr(rxDestAddr), .userPattern(userPattern),
    .daHit(daHit), .daMiss(daMiss)
  );

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Called right after a rising edge; returns at the edge that ends the data phase.
  task automatic busXfer(input logic [IDX_W-1:0] idx, input logic wr, input logic [2:0] sz,
                         input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    haddr <= {18'h0_0000, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd);
    logic [DATA_W-1:0] dummy;
    busXfer(idx, 1'b1, HSIZE_WORD, wd, dummy);
  endtask

  task automatic rdChk(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] got;
    busXfer(idx, 1'b0, HSIZE_WORD, WORD_ZERO, got);
    chk(got, exp);
  endtask

  task automatic pktBurst(input logic rx, input int n, input logic err);
    repeat (n) begin
      @(posedge sys_clk);
      if (rx) rxPkt <= '{done: 1'b1, crcErr: err};
      else txPkt <= '{done: 1'b1, crcErr: err};
    end
    @(posedge sys_clk);
    txPkt <= '0;
    rxPkt <= '0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testReset();
    logic [IDX_W-1:0] idx [13] = '{IDX_PAT_LOW, IDX_PAT_MID, IDX_PAT_HIGH, IDX_DA_LOW,
      IDX_DA_MID, IDX_DA_HIGH, IDX_CRC, IDX_TX_LOW, IDX_TX_HIGH, IDX_TX_FAULT, IDX_RX_LOW,
      IDX_RX_HIGH, IDX_RX_FAULT};
    foreach (idx[i]) rdChk(idx[i], WORD_ZERO);
    chk({16'h0000, userPattern[15:0]}, WORD_ZERO);
  endtask

  task automatic testReadWrite();
    for (int i = 0; i < NUM_RW; i++) begin
      pat[i] = 16'ha000 + 16'(i) * 16'h0111;
      wr(RW_IDX[i], {16'hffff, pat[i]});
      rdChk(RW_IDX[i], {16'h0000, pat[i]});
    end
    chk(userPattern[47:16], {pat[RW_PAT_HIGH], pat[RW_PAT_MID]});
    chk({16'h0000, userPattern[15:0]}, {16'h0000, pat[RW_PAT_LOW]});
  endtask

  task automatic testRefused();
    logic [DATA_W-1:0] dummy;
    // A halfword write must leave the stored word alone.
    busXfer(IDX_PAT_LOW, 1'b1, 3'h1, 32'h0000_dead, dummy);
    rdChk(IDX_PAT_LOW, {16'h0000, pat[RW_PAT_LOW]});
    wr(IDX_CRC, 32'h0000_ffff);
    rdChk(IDX_CRC, WORD_ZERO);
    rdChk(12'h700, WORD_ZERO);
  endtask

  task automatic daProbe(input logic [PAT_W-1:0] a, input logic [1:0] exp);
    rxDestAddr <= a;
    rxDaValid <= 1'b1;
    @(posedge sys_clk);
    rxDaValid <= 1'b0;
    #1;
    chk({30'h0, daHit, daMiss}, {30'h0, exp});
    @(posedge sys_clk);
  endtask

  task automatic testMatch();
    logic [PAT_W-1:0] m;
    m = {pat[RW_DA_HIGH], pat[RW_DA_MID], pat[RW_DA_LOW]};
    daProbe(m, 2'b10);
    daProbe(m ^ 48'h8000_0000_0000, 2'b01);
    daProbe(m ^ 48'h0000_0000_0001, 2'b01);
  endtask

  task automatic testTxStats();
    // Crossing 2^16 packets proves the upper half is a real carry.
    pktBurst(1'b0, 3, 1'b1);
    pktBurst(1'b0, 65534, 1'b0);
    rdChk(IDX_TX_LOW, 32'h0000_0001);
    rdChk(IDX_TX_HIGH, 32'h0000_0001);
    rdChk(IDX_TX_FAULT, 32'h0000_0003);
    rdChk(IDX_TX_FAULT, WORD_ZERO);
    rdChk(IDX_TX_LOW, WORD_ZERO);
  endtask

  task automatic testFlags();
    pktBurst(1'b0, 1, 1'b1);
    rdChk(IDX_CRC, 32'h0000_0001);
    pktBurst(1'b1, 1, 1'b1);
    rdChk(IDX_CRC, 32'h0000_0003);
  endtask

  task automatic testRxStats();
    pktBurst(1'b1, 4, 1'b0);
    rdChk(IDX_RX_LOW, 32'h0000_0005);
    rdChk(IDX_CRC, 32'h0000_0001);
    rdChk(IDX_RX_HIGH, WORD_ZERO);
    rdChk(IDX_RX_FAULT, 32'h0000_0001);
    rdChk(IDX_RX_LOW, 32'h0000_0005);
    rdChk(IDX_RX_HIGH, WORD_ZERO);
    rdChk(IDX_RX_FAULT, 32'h0000_0001);
    rdChk(IDX_RX_LOW, WORD_ZERO);
    rdChk(IDX_RX_FAULT, WORD_ZERO);
  endtask

  // ****************************************
  // Verdict, watchdog and main sequence
  // ****************************************
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    // The full run needs about 66000 cycles, mostly the long transmit burst.
    repeat (90000) @(posedge sys_clk);
    fails++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
    summarize();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    hsel <= 1'b1;
    @(posedge sys_clk);
    testReset();
    testReadWrite();
    testRefused();
    testMatch();
    testTxStats();
    testFlags();
    testRxStats();
    summarize();
  end
endmodule
